// ### design/gpio_strap_pkg.sv
// Package for the general-purpose pin and strap block.
// Assumes a single core clock at 200 MHz and a synchronous active-low reset.
package gpio_strap_pkg;

   localparam int unsigned PIN_COUNT       = 18;
   localparam int unsigned STRAP_COUNT     = 3;

   // Pin positions in the pin vectors
   localparam int unsigned PIN_MUX_MODE    = 0;
   localparam int unsigned PIN_STRAP_A     = 1;
   localparam int unsigned PIN_MUX_EN      = 3;
   localparam int unsigned PIN_HOTPLUG_TX  = 4;
   localparam int unsigned PIN_HOTPLUG_RX  = 5;
   localparam int unsigned PIN_MAN_RESET   = 11;
   localparam int unsigned PIN_STRAP_C     = 12;
   localparam int unsigned PIN_STRAP_B     = 13;
   localparam int unsigned PIN_MUX_POL     = 14;
   localparam int unsigned PIN_ADDR_BIT4   = 16;
   localparam int unsigned PIN_ADDR_BIT5   = 17;

   // Hot plug pin modes
   localparam logic [1:0] HPD_OFF          = 2'h0;
   localparam logic [1:0] HPD_TX           = 2'h1;
   localparam logic [1:0] HOTPLUG_RX_PIN           = 2'h2;
   localparam logic [1:0] HOTPLUG_TX_RX_PIN         = 2'h3;

   // Cycles after reset release before straps are latched
   localparam int unsigned STRAP_SETTLE_NS = 100;
   localparam int unsigned CLK_PERIOD_PS   = 5000;
   localparam int unsigned STRAP_SETTLE_CYC =
      (STRAP_SETTLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

   // Reset values
   localparam logic        RST_OE_N        = 1'b1;
   localparam logic        RST_SYS_RESET_N = 1'b0;
   localparam logic        RST_MANUAL_RESET_IN_POL  = 1'b1;

endpackage : gpio_strap_pkg

// ### design/strap_sampler.sv
// Strap sampler: waits a settle count after reset or restart, then latches straps once.
// Assumes board holds strap pins at static levels.
`timescale 1ns/1ps
`default_nettype none
module strap_sampler #(
   parameter int unsigned WIDTH  = 6,
   parameter int unsigned SETTLE = 20
) (
   // Clock and reset
   input  wire  logic             i_mclk,
   input  wire  logic             i_rst_n,
   input  wire  logic             i_restart,
   // Strap levels
   input  wire  logic [WIDTH-1:0] i_straps,
   output logic       [WIDTH-1:0] o_latched,
   output logic                   o_done
);
   logic [7:0] cnt_q;

   always_ff @(posedge i_mclk) begin
      if (!i_rst_n || i_restart) begin
         cnt_q <= 8'h00;
         o_done <= 1'b0;
      end else if (!o_done) begin
         if (cnt_q == 8'(SETTLE - 1)) begin
            o_done <= 1'b1;
         end
         cnt_q <= cnt_q + 8'h01;
      end
   end

   // Level caught after release, never under reset
   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         o_latched <= '0;
      end else if (!o_done && !i_restart && cnt_q == 8'(SETTLE - 1)) begin
         o_latched <= i_straps;
      end
   end
endmodule : strap_sampler
`default_nettype wire

// ### design/reset_gen.sv
// Reset output generator with manual reset of selectable polarity.
// Assumes supply-good and manual reset inputs are synchronous.
`timescale 1ns/1ps
`default_nettype none
module reset_gen (
   // Clock and reset
   input  wire  logic i_mclk,
   input  wire  logic i_rst_n,
   // Controls
   input  wire  logic i_supply_good,
   input  wire  logic i_manual_reset_in,
   input  wire  logic i_manual_reset_in_pol,
   output logic       o_reset_n
);
   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         o_reset_n <= gpio_strap_pkg::RST_SYS_RESET_N;
      end else begin
         o_reset_n <= i_supply_good && (i_manual_reset_in != i_manual_reset_in_pol);
      end
   end
endmodule : reset_gen
`default_nettype wire

// ### design/gpio_strap_reset_pins.sv
// General-purpose pin, strap and reset block of a Type-C controller.
// Assumes pins are resolved outside from output, output enable (low = drive).
// How it works
// - Mux mode select pin can be driven or left tri-stated.
// - Mux mode select level tells the external mux the alternate mode.
// - Mux enable pin switches the external mux on or off.
// - Mux polarity pin reports cable orientation to the external mux.
// - Hot plug pin configurable as transmitter, receiver or both.
// - Second hot plug pin configurable as receiver.
// - Any general-purpose pin except the manual reset pin can be a push-pull output.
// - Three configuration straps are read; board holds them static.
// - Reset output driven low while the 3.3 V supply is low.
// - Manual reset forces reset output; polarity programmable, high by default.
// - First debug strap sensed at power-up forms address bit 4.
// - Second debug strap sensed at power-up forms address bit 5.
// - Bus-power strap sampled at boot; high disables both high-voltage paths.
// - Hard reset input high resets the block; its release requests a flash reload.
`timescale 1ns/1ps
`default_nettype none
module gpio_strap_reset_pins #(
   parameter int unsigned PINS = gpio_strap_pkg::PIN_COUNT
) (
   // Clock and reset
   input  wire  logic            i_mclk,
   input  wire  logic            i_rst_n,
   // Pin pads
   input  wire  logic [PINS-1:0] i_pin,
   output logic       [PINS-1:0] o_pin,
   output logic       [PINS-1:0] o_pin_oe_n,
   // Generic pin configuration
   input  wire  logic [PINS-1:0] i_gpio_out_en,
   input  wire  logic [PINS-1:0] i_gpio_out_val,
   output logic       [PINS-1:0] o_gpio_in,
   // External mux control
   input  wire  logic            i_mux_ctrl_en,
   input  wire  logic            i_mux_mode_tristate,
   input  wire  logic            i_mux_mode_select,
   input  wire  logic            i_mux_enable_out,
   input  wire  logic            i_mux_polarity_out,
   // Hot plug
   input  wire  logic            i_dp_supported,
   input  wire  logic [1:0]      i_hotplug_tx_rx_mode,
   input  wire  logic            i_hotplug_tx_level,
   input  wire  logic            i_hotplug_rx_en,
   output logic                  o_hotplug_tx_rx_pin,
   output logic                  o_hotplug_rx_pin,
   // Reset pins and straps
   input  wire  logic            i_aux_supply_good,
   input  wire  logic            i_manual_reset_low_active,
   input  wire  logic            i_hard_reset_in,
   input  wire  logic            i_bus_power_strap,
   output logic                  o_sys_reset_out_n,
   output logic                  o_flash_reload,
   output logic [2:0]            o_strap_cfg,
   output logic [1:0]            o_i2c_addr_hi,
   output logic                  o_hv_paths_disable,
   output logic                  o_straps_valid
);
   localparam int unsigned SW = gpio_strap_pkg::STRAP_COUNT + 3;

   logic            run_rst_n;
   logic            hard_q;
   logic [SW-1:0]   straps;
   logic [SW-1:0]   latched;
   logic            done;
   logic            reset_n;
   logic            manual_reset_in_pol;
   logic [PINS-1:0] out_d;
   logic [PINS-1:0] oe_n_d;

   // Hard reset holds the block in reset like power-on
   assign run_rst_n = i_rst_n && !i_hard_reset_in;

   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         hard_q <= 1'b0;
         o_flash_reload <= 1'b0;
      end else begin
         hard_q <= i_hard_reset_in;
         o_flash_reload <= hard_q && !i_hard_reset_in;
      end
   end

   assign straps = {i_bus_power_strap,
                    i_pin[gpio_strap_pkg::PIN_ADDR_BIT5],
                    i_pin[gpio_strap_pkg::PIN_ADDR_BIT4],
                    i_pin[gpio_strap_pkg::PIN_STRAP_C],
                    i_pin[gpio_strap_pkg::PIN_STRAP_B],
                    i_pin[gpio_strap_pkg::PIN_STRAP_A]};

   strap_sampler #(
      .WIDTH  (SW),
      .SETTLE (gpio_strap_pkg::STRAP_SETTLE_CYC)
   ) u_straps (
      .i_mclk    (i_mclk),
      .i_rst_n   (i_rst_n),
      .i_restart (i_hard_reset_in),
      .i_straps  (straps),
      .o_latched (latched),
      .o_done    (done)
   );

   always_ff @(posedge i_mclk) begin
      if (!run_rst_n) begin
         o_strap_cfg <= 3'h0;
         o_i2c_addr_hi <= 2'h0;
         o_hv_paths_disable <= 1'b0;
         o_straps_valid <= 1'b0;
      end else begin
         o_strap_cfg <= latched[2:0];
         o_i2c_addr_hi <= {latched[4], latched[3]};
         o_hv_paths_disable <= latched[5] && done;
         o_straps_valid <= done;
      end
   end

   // Low-active option inverts the default; no extra stage, so reset out stays two cycles
   assign manual_reset_in_pol = gpio_strap_pkg::RST_MANUAL_RESET_IN_POL ^ i_manual_reset_low_active;

   reset_gen u_reset (
      .i_mclk        (i_mclk),
      .i_rst_n       (run_rst_n),
      .i_supply_good (i_aux_supply_good),
      .i_manual_reset_in      (i_pin[gpio_strap_pkg::PIN_MAN_RESET]),
      .i_manual_reset_in_pol  (manual_reset_in_pol),
      .o_reset_n     (reset_n)
   );

   always_comb begin
      out_d = i_gpio_out_val;
      oe_n_d = ~i_gpio_out_en;
      oe_n_d[gpio_strap_pkg::PIN_MAN_RESET] = 1'b1;
      if (i_mux_ctrl_en) begin
         out_d[gpio_strap_pkg::PIN_MUX_MODE] = i_mux_mode_select;
         oe_n_d[gpio_strap_pkg::PIN_MUX_MODE] = i_mux_mode_tristate;
         out_d[gpio_strap_pkg::PIN_MUX_EN] = i_mux_enable_out;
         oe_n_d[gpio_strap_pkg::PIN_MUX_EN] = 1'b0;
         out_d[gpio_strap_pkg::PIN_MUX_POL] = i_mux_polarity_out;
         oe_n_d[gpio_strap_pkg::PIN_MUX_POL] = 1'b0;
      end
      if (i_dp_supported) begin
         out_d[gpio_strap_pkg::PIN_HOTPLUG_TX] = i_hotplug_tx_level;
         oe_n_d[gpio_strap_pkg::PIN_HOTPLUG_TX] = !i_hotplug_tx_rx_mode[0];
         if (i_hotplug_rx_en) begin
            oe_n_d[gpio_strap_pkg::PIN_HOTPLUG_RX] = 1'b1;
         end
      end
   end

   always_ff @(posedge i_mclk) begin
      if (!run_rst_n) begin
         o_pin <= '0;
         o_pin_oe_n <= {PINS{gpio_strap_pkg::RST_OE_N}};
         o_gpio_in <= '0;
      end else begin
         o_pin <= out_d;
         o_pin_oe_n <= oe_n_d;
         o_gpio_in <= i_pin;
      end
   end

   always_ff @(posedge i_mclk) begin
      if (!run_rst_n) begin
         o_hotplug_tx_rx_pin <= 1'b0;
         o_hotplug_rx_pin <= 1'b0;
      end else begin
         o_hotplug_tx_rx_pin <= i_dp_supported && i_hotplug_tx_rx_mode[1]
                                && i_pin[gpio_strap_pkg::PIN_HOTPLUG_TX];
         o_hotplug_rx_pin <= i_dp_supported && i_hotplug_rx_en
                             && i_pin[gpio_strap_pkg::PIN_HOTPLUG_RX];
      end
   end

   always_ff @(posedge i_mclk) begin
      if (!run_rst_n) begin
         o_sys_reset_out_n <= gpio_strap_pkg::RST_SYS_RESET_N;
      end else begin
         o_sys_reset_out_n <= reset_n;
      end
   end

endmodule : gpio_strap_reset_pins
`default_nettype wire

// ### sim/gpio_strap_board.sv
// Board model: strap and pull resistors, and the level seen on each pad.
// Assumes the block drives a pad only while its output enable is low.
`timescale 1ns/1ps
`default_nettype none
module gpio_strap_board (
   // Resistor levels and block drive
   input  wire logic [17:0] i_pull,
   input  wire logic [17:0] i_drive,
   input  wire logic [17:0] i_drive_oe_n,
   // Resolved pad levels
   output logic      [17:0] o_level
);
   // Released pads fall to their resistor level; strap levels stay static
   assign o_level = (i_drive & ~i_drive_oe_n) | (i_pull & i_drive_oe_n);
endmodule : gpio_strap_board
`default_nettype wire

// ### sim/gpio_strap_reset_pins_monitor.sv
// Checker of the pin, strap and reset block.
// Bound into the block; sees its ports only.
`timescale 1ns/1ps
`default_nettype none
module gpio_strap_reset_pins_monitor #(
   parameter int unsigned PINS = gpio_strap_pkg::PIN_COUNT
) (
   // Watched ports
   input wire logic i_mclk, i_rst_n, i_hard_reset_in, i_mux_ctrl_en, i_mux_mode_tristate,
   input wire logic i_mux_mode_select, i_mux_enable_out, i_mux_polarity_out, i_dp_supported,
   input wire logic i_hotplug_tx_level, i_hotplug_rx_en, i_aux_supply_good, i_bus_power_strap,
   input wire logic i_manual_reset_low_active, o_hotplug_tx_rx_pin, o_hotplug_rx_pin,
   input wire logic o_sys_reset_out_n, o_flash_reload, o_hv_paths_disable, o_straps_valid,
   input wire logic [1:0] i_hotplug_tx_rx_mode, o_i2c_addr_hi,
   input wire logic [2:0] o_strap_cfg,
   input wire logic [PINS-1:0] i_pin, o_pin, o_pin_oe_n, i_gpio_out_en, i_gpio_out_val, o_gpio_in
);
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_rst_n);
   wire logic hr = i_hard_reset_in;
   wire logic mr = i_pin[11] ^ i_manual_reset_low_active;
   gpio_drive_a: assert property (i_gpio_out_en[2] && !hr |=> !o_pin_oe_n[2] &&
      o_pin[2] == $past(i_gpio_out_val[2])) else $error("gpio drive");
   mux_mode_a: assert property (i_mux_ctrl_en && !hr |=>
      o_pin_oe_n[0] == $past(i_mux_mode_tristate) &&
      (o_pin_oe_n[0] || o_pin[0] == $past(i_mux_mode_select))) else $error("mux mode");
   mux_ctrl_a: assert property (i_mux_ctrl_en && !hr |=> !o_pin_oe_n[3] && !o_pin_oe_n[14] &&
      o_pin[3] == $past(i_mux_enable_out) && o_pin[14] == $past(i_mux_polarity_out))
      else $error("mux ctrl");
   hpd_tx_a: assert property (i_dp_supported && i_hotplug_tx_rx_mode[0] && !i_gpio_out_en[4]
      && !hr |=> !o_pin_oe_n[4] && o_pin[4] == $past(i_hotplug_tx_level)) else $error("hpd tx");
   hotplug_rx_pin_a: assert property (i_dp_supported && i_hotplug_tx_rx_mode[1] && !hr |=>
      o_hotplug_tx_rx_pin == $past(i_pin[4])) else $error("hotplug_rx_pin");
   hpd_rx2_a: assert property (i_dp_supported && i_hotplug_rx_en && !hr |=> o_pin_oe_n[5] &&
      o_hotplug_rx_pin == $past(i_pin[5])) else $error("hpd rx2");
   rst_low_a: assert property (!i_aux_supply_good || mr |-> ##2 !o_sys_reset_out_n)
      else $error("reset out low");
   rst_high_a: assert property ((i_aux_supply_good && !mr && !hr) [*3] ##1 !hr |-> ##1
      o_sys_reset_out_n) else $error("reset out high");
   hard_rst_a: assert property (hr |=> &o_pin_oe_n && !o_sys_reset_out_n && !o_straps_valid)
      else $error("hard reset");
   reload_a: assert property ($fell(hr) |=> o_flash_reload ##1 !o_flash_reload)
      else $error("reload");
   strap_a: assert property ($rose(o_straps_valid) |-> o_hv_paths_disable == i_bus_power_strap
      && o_i2c_addr_hi == {i_pin[17], i_pin[16]} && o_strap_cfg == {i_pin[12], i_pin[13], i_pin[1]})
      else $error("strap latch");
   gpio_in_a: assert property (!hr |=> o_gpio_in == $past(i_pin))
      else $error("gpio input");
   cover property ($fell(hr));
   cover property ($rose(o_straps_valid));
   cover property (i_mux_ctrl_en && i_mux_mode_tristate);
endmodule : gpio_strap_reset_pins_monitor
bind gpio_strap_reset_pins gpio_strap_reset_pins_monitor #(.PINS(PINS)) u_mon (.*);
`default_nettype wire

// ### sim/tb_gpio_strap_reset_pins.sv
// Bench for the pin, strap and reset block.
// Board model resolves the pads; outputs are checked against queued notes.
`timescale 1ns/1ps
`default_nettype none
module tb_gpio_strap_reset_pins;
   localparam logic [17:0] GP = 18'h085c4;
   logic i_mclk = 1'b0, i_rst_n = 1'b0, i_mux_ctrl_en = 1'b0, i_mux_mode_tristate = 1'b0;
   logic i_mux_mode_select = 1'b0, i_mux_enable_out = 1'b0, i_mux_polarity_out = 1'b0;
   logic i_dp_supported = 1'b0, i_hotplug_tx_level = 1'b0, i_hotplug_rx_en = 1'b0;
   logic i_aux_supply_good = 1'b1, i_manual_reset_low_active = 1'b0, i_hard_reset_in = 1'b0;
   logic i_bus_power_strap, o_hotplug_tx_rx_pin, o_hotplug_rx_pin, o_sys_reset_out_n;
   logic o_flash_reload, o_hv_paths_disable, o_straps_valid;
   logic [1:0] i_hotplug_tx_rx_mode = 2'h0, o_i2c_addr_hi;
   logic [2:0] o_strap_cfg;
   logic [17:0] i_gpio_out_en = 18'h0, i_gpio_out_val = 18'h0, pull, i_pin, o_pin, o_pin_oe_n;
   logic [17:0] o_gpio_in;
   logic [31:0] seed = 32'h5a87a8cb;
   logic [46:0] obs;
   logic [93:0] nt, q[$];
   int mismatches = 0, comparisons = 0;
   assign obs = {o_flash_reload, o_straps_valid, o_hv_paths_disable, o_i2c_addr_hi, o_strap_cfg,
                 o_sys_reset_out_n, o_hotplug_rx_pin, o_hotplug_tx_rx_pin, o_pin_oe_n, o_pin};
   gpio_strap_reset_pins u_dut (.*);
   gpio_strap_board u_board (.i_pull(pull), .i_drive(o_pin), .i_drive_oe_n(o_pin_oe_n),
                             .o_level(i_pin));
   always #2.5 i_mclk = ~i_mclk;
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : xs
   task automatic cyc(int n);
      repeat (n) @(posedge i_mclk);
   endtask : cyc
   task automatic note(logic [46:0] m, logic [46:0] e);
      q.push_back({m, e});
   endtask : note
   always @(negedge i_mclk) begin
      if (q.size() > 0) begin
         nt = q.pop_front();
         comparisons++;
         if (((obs ^ nt[46:0]) & nt[93:47]) !== 47'h0) begin
            mismatches++;
            $display("MISMATCH %0t got %h want %h mask %h", $time, obs, nt[46:0], nt[93:47]);
         end
      end
   end
   task automatic straps();
      int n;
      for (n = 0; n < 40 && o_straps_valid !== 1'b1; n++) @(negedge i_mclk);
      comparisons++;
      if (n < 20 || n > 39) begin
         mismatches++;
         $display("MISMATCH %0t strap wait %0d", $time, n);
         if (n > 39) test_done();
      end
      @(posedge i_mclk);
      note({2'h1, 6'h3f, 39'h0}, {2'h1, i_bus_power_strap, pull[17], pull[16],
           pull[12], pull[13], pull[1], 39'h0});
   endtask : straps
   task automatic test_done();
      $display("Checks %0d, mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : test_done
   initial begin
      logic [31:0] r;
      logic t, x, y;
      r = xs();
      pull = r[17:0] & 18'h3f7ff;
      i_bus_power_strap = r[18];
      cyc(2);
      i_rst_n <= 1'b1;
      note({9'h001, 20'h3ffff, 18'h0}, {9'h0, 20'h3ffff, 18'h0});
      straps();
      repeat (8) begin
         r = xs();
         @(posedge i_mclk);
         i_gpio_out_en <= r[17:0] & GP;
         i_gpio_out_val <= r[31:14];
         @(posedge i_mclk);
         note({11'h0, GP, r[17:0] & GP}, {11'h0, ~r[17:0] & GP, r[31:14] & r[17:0] & GP});
      end
      for (int i = 0; i < 4; i++) begin
         r = xs();
         r[31] = i[0];
         @(posedge i_mclk);
         i_gpio_out_en <= 18'h04009;
         i_gpio_out_val <= r[17:0];
         i_mux_ctrl_en <= 1'b1;
         {i_mux_mode_tristate, i_mux_mode_select, i_mux_enable_out, i_mux_polarity_out} <= r[31:28];
         @(posedge i_mclk);
         note({11'h0, 18'h04009, 18'h04008 | {17'h0, ~r[31]}},
              {28'h0, r[31], 3'h0, r[28], 10'h0, r[29], 2'h0, r[30]});
      end
      for (int i = 0; i < 5; i++) begin
         r = xs();
         t = (i < 4) && i[0];
         x = (i < 4) && i[1];
         y = (i < 4) && !i[0];
         @(posedge i_mclk);
         i_dp_supported <= (i < 4);
         i_hotplug_tx_rx_mode <= (i < 4) ? i[1:0] : 2'h3;
         i_hotplug_tx_level <= r[0];
         i_hotplug_rx_en <= !i[0];
         cyc(3);
         note({9'h0, 2'h3, 12'h0, y, 5'h10, 13'h0, t, 4'h0}, {9'h0, y & pull[5],
              x & (t ? r[0] : pull[4]), 12'h0, 1'b1, !t, 4'h0, 13'h0, r[0], 4'h0});
      end
      for (int i = 0; i < 8; i++) begin
         @(posedge i_mclk);
         i_aux_supply_good <= i[0];
         i_manual_reset_low_active <= i[1];
         pull[11] <= i[2];
         cyc(3);
         note({8'h0, 1'b1, 38'h0}, {8'h0, i[0] && (i[2] == i[1]), 38'h0});
      end
      @(posedge i_mclk);
      i_gpio_out_en <= GP;
      @(posedge i_mclk);
      i_hard_reset_in <= 1'b1;
      @(posedge i_mclk);
      note({9'h081, 20'h3ffff, 18'h0}, {9'h0, 20'h3ffff, 18'h0});
      cyc(2);
      i_hard_reset_in <= 1'b0;
      @(posedge i_mclk);
      note({1'b1, 46'h0}, {1'b1, 46'h0});
      straps();
      cyc(2);
      test_done();
   end
endmodule : tb_gpio_strap_reset_pins
`default_nettype wire
